//--- rtl/pat_timer.sv
/*
 * 8-bit auto-reload PWM timer with four PWM channels and two input captures,
 * registers reached over APB.
 * Assumes synchronous inputs except the capture pins, a single clock and a
 * synchronous active-high reset.
 */
// Functional notes
// - Clock select bit picks prescaler input: 0 system clock, 1 external clock
// - Three-bit field divides the input clock by two to its power
// - Enable low freezes prescaler and counter; high lets counter run
// - Force reload is write-only, reads zero, loads reload value, clears prescaler
// - Overflow interrupt enable gates the overflow request
// - Overflow flag set on FFh wrap, cleared by reading control/status
// - Counter register reads live count; writes update it while running
// - Each overflow loads the counter from the reload register
// - At each overflow reload, outputs take their period-start level
// - Reload value sets period and resolution as 256 minus reload
// - Four output enables connect each channel to its pin independently
// - Polarity 0: high while count at most compare; polarity 1 inverts
// - Polarity change inverts the output immediately
// - Duty register gives the second edge; reload gives the common first
// - Top two bits of capture control/status read zero
// - Capture sensitivity bit: 0 falling edge, 1 rising edge
// - Capture interrupt enables mask each channel independently
// - Capture sets channel flag; reading its capture register clears it
// - Capture register holds the counter value taken at the event
// - Every register resets to zero
// - Hidden compare registers reload from duty registers at each overflow
// - After a capture, further captures blocked until the register is read
// - Capture inputs synchronised to the system clock before latching
// - Counter steps on each prescaled tick; overflow reload leaves prescaler alone
`timescale 1ns/10ps
module pat_timer #(
    parameter int NUM_PWM = 4,
    parameter int NUM_CAP = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pat_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [pat_pkg::DATA_W-1:0] pwdata_i,
    output logic [pat_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ext_clk_i,
    input wire logic [NUM_CAP-1:0] capture_input_pin_i,
    output logic [NUM_PWM-1:0] pwm_output_pin_o,
    output logic [NUM_PWM-1:0] pwm_output_pin_oe_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PWM-1:0][7:0] duty;
        logic [NUM_PWM-1:0][7:0] ocr;
        logic [NUM_PWM-1:0] oe;
        logic [NUM_PWM-1:0] op;
        logic ext_clock_select;
        logic [2:0] cc;
        logic counter_run_enable;
        logic overflow_irq_enable;
        logic ovf;
        logic [7:0] cnt;
        logic [7:0] arr;
        logic [6:0] psc;
        logic ext_prev;
        logic [NUM_CAP-1:0] cs;
        logic [NUM_CAP-1:0] cie;
        logic [NUM_CAP-1:0] cf;
        logic [NUM_CAP-1:0][7:0] icr;
        logic [NUM_CAP-1:0] cf_rd_ok;
        logic ovf_rd_ok;
        logic [pat_pkg::DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic [NUM_PWM-1:0] pwm;
        logic [NUM_PWM-1:0] pwm_oe;
        logic irq;
    } pat_state_t;

    pat_state_t s_r;
    pat_state_t s_nxt;

    logic [NUM_CAP-1:0] cap_ev;
    logic [5:0] idx;
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic in_tick;
    logic cnt_tick;
    logic ovf_ev;
    logic [6:0] psc_mask;
    logic [7:0] wdat;

    // ----------------------------------------------------------------
    // Capture synchronisers
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_CAP; g++) begin : g_cap
            pat_cap_sync u_sync (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(capture_input_pin_i[g]),
                .rising_sel_i(s_r.cs[g]),
                .event_o(cap_ev[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Bus decode and clock ticks
    // ----------------------------------------------------------------
    assign idx = paddr_i[7:2];
    assign setup = psel_i & ~penable_i;
    assign acc = psel_i & penable_i & s_r.pready;
    assign wr = acc & pwrite_i;
    assign rd = acc & ~pwrite_i;
    assign wdat = pwdata_i[7:0];
    assign in_tick = s_r.ext_clock_select ? (ext_clk_i & ~s_r.ext_prev) : 1'b1;
    assign psc_mask = 7'((8'h01 << s_r.cc) - 8'h01);
    assign cnt_tick = s_r.counter_run_enable & in_tick & ((s_r.psc & psc_mask) == psc_mask);
    assign ovf_ev = cnt_tick & (s_r.cnt == pat_pkg::CNT_TOP);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] rdat;
        logic hit;
        logic lvl;
        logic [NUM_CAP-1:0] clr;
        rdat = 8'h00;
        hit = 1'b1;
        lvl = 1'b0;
        clr = '0;
        s_nxt = s_r;
        s_nxt.ext_prev = ext_clk_i;

        // Read mux
        case (idx)
            pat_pkg::IDX_PWMCTL: rdat = {s_r.oe, s_r.op};
            pat_pkg::IDX_CSR: begin
                rdat = {s_r.ext_clock_select, s_r.cc, s_r.counter_run_enable, 1'b0, s_r.overflow_irq_enable, s_r.ovf};
            end
            pat_pkg::IDX_CNT: rdat = s_r.cnt;
            pat_pkg::IDX_ARR: rdat = s_r.arr;
            pat_pkg::IDX_CAPCSR: rdat = {2'b00, s_r.cs, s_r.cie, s_r.cf};
            pat_pkg::IDX_CAP1: rdat = s_r.icr[0];
            pat_pkg::IDX_CAP2: rdat = s_r.icr[1];
            pat_pkg::IDX_DUTY3: rdat = s_r.duty[3];
            pat_pkg::IDX_DUTY2: rdat = s_r.duty[2];
            pat_pkg::IDX_DUTY1: rdat = s_r.duty[1];
            pat_pkg::IDX_DUTY0: rdat = s_r.duty[0];
            default: hit = 1'b0;
        endcase

        // APB answer, one wait-free access phase
        s_nxt.pready = setup;
        s_nxt.pslverr = setup & ~hit;
        s_nxt.prdata = (setup & hit) ? {24'h000000, rdat} : 32'h00000000;
        if (setup) begin
            s_nxt.ovf_rd_ok = (idx == pat_pkg::IDX_CSR) & s_r.ovf;
            s_nxt.cf_rd_ok[0] = (idx == pat_pkg::IDX_CAP1) & s_r.cf[0];
            s_nxt.cf_rd_ok[1] = (idx == pat_pkg::IDX_CAP2) & s_r.cf[1];
        end

        // Prescaler and counter
        if (s_r.counter_run_enable & in_tick) begin
            s_nxt.psc = s_r.psc + 7'h01;
        end
        if (cnt_tick) begin
            s_nxt.cnt = ovf_ev ? s_r.arr : s_r.cnt + 8'h01;
        end
        if (ovf_ev) begin
            s_nxt.cnt = s_r.arr;
            s_nxt.ocr = s_r.duty;
        end

        // Register writes
        if (wr) begin
            case (idx)
                pat_pkg::IDX_PWMCTL: begin
                    s_nxt.oe = wdat[pat_pkg::PWM_OE_LSB +: 4];
                    s_nxt.op = wdat[pat_pkg::PWM_OP_LSB +: 4];
                end
                pat_pkg::IDX_CSR: begin
                    s_nxt.ext_clock_select = wdat[pat_pkg::CSR_EXT_CLOCK_SELECT];
                    s_nxt.cc = wdat[pat_pkg::CSR_CC_LSB +: 3];
                    s_nxt.counter_run_enable = wdat[pat_pkg::CSR_TCE];
                    s_nxt.overflow_irq_enable = wdat[pat_pkg::CSR_OIE];
                    if (wdat[pat_pkg::CSR_FORCE_RELOAD]) begin
                        s_nxt.cnt = s_r.arr;
                        s_nxt.psc = 7'h00;
                    end
                end
                pat_pkg::IDX_CNT: begin
                    s_nxt.cnt = wdat;
                    s_nxt.psc = 7'h00;
                end
                pat_pkg::IDX_ARR: s_nxt.arr = wdat;
                pat_pkg::IDX_CAPCSR: begin
                    s_nxt.cs = wdat[pat_pkg::CAP_CS_LSB +: 2];
                    s_nxt.cie = wdat[pat_pkg::CAP_CIE_LSB +: 2];
                end
                pat_pkg::IDX_DUTY3: s_nxt.duty[3] = wdat;
                pat_pkg::IDX_DUTY2: s_nxt.duty[2] = wdat;
                pat_pkg::IDX_DUTY1: s_nxt.duty[1] = wdat;
                pat_pkg::IDX_DUTY0: s_nxt.duty[0] = wdat;
                default: s_nxt.ovf = s_r.ovf;
            endcase
        end

        // Overflow flag: set wins over read clear
        s_nxt.ovf = ovf_ev | (s_r.ovf & ~(rd & (idx == pat_pkg::IDX_CSR) & s_r.ovf_rd_ok));

        // Capture channels
        for (int k = 0; k < NUM_CAP; k++) begin
            clr[k] = rd & s_r.cf_rd_ok[k] &
                (idx == (k == 0 ? pat_pkg::IDX_CAP1 : pat_pkg::IDX_CAP2));
            if (cap_ev[k] & (~s_r.cf[k] | clr[k])) begin
                s_nxt.icr[k] = s_r.cnt;
                s_nxt.cf[k] = 1'b1;
            end else if (clr[k]) begin
                s_nxt.cf[k] = 1'b0;
            end
        end

        // PWM outputs from next count, compare and polarity
        for (int k = 0; k < NUM_PWM; k++) begin
            lvl = (s_nxt.cnt <= s_nxt.ocr[k]) ^ s_nxt.op[k];
            s_nxt.pwm[k] = s_nxt.oe[k] & lvl;
        end
        s_nxt.pwm_oe = s_nxt.oe;

        // Interrupt request
        s_nxt.irq = (s_nxt.ovf & s_nxt.overflow_irq_enable) | (|(s_nxt.cf & s_nxt.cie));
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o = s_r.prdata;
    assign pready_o = s_r.pready;
    assign pslverr_o = s_r.pslverr;
    assign pwm_output_pin_o = s_r.pwm;
    assign pwm_output_pin_oe_o = s_r.pwm_oe;
    assign irq_o = s_r.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_CAPCSR_RSVD_ZERO: assert property (
        (s_r.pready & psel_i & idx == pat_pkg::IDX_CAPCSR) |-> (prdata_o[7:6] == 2'b00))
        else $error("Reserved capture status bits not zero");

    AST_FORCE_RELOAD_READS_ZERO: assert property (
        (s_r.pready & psel_i & idx == pat_pkg::IDX_CSR) |-> (prdata_o[pat_pkg::CSR_FORCE_RELOAD] == 1'b0))
        else $error("Force reload bit read as one");

    AST_OVF_RELOAD: assert property (
        (ovf_ev & ~wr) |=> (s_r.cnt == $past(s_r.arr)) && s_r.ovf)
        else $error("Overflow did not reload counter and set flag");

    AST_STOPPED_HOLD: assert property (
        (~s_r.counter_run_enable & ~wr) |=> ($stable(s_r.cnt) && $stable(s_r.psc)))
        else $error("Counter moved while disabled");

    AST_OCR_FROM_DUTY: assert property (
        ovf_ev |=> (s_r.ocr == $past(s_r.duty)))
        else $error("Compare values not loaded at overflow");

    AST_PWM_LEVEL: assert property (
        pwm_output_pin_o[0] == (s_r.oe[0] & ((s_r.cnt <= s_r.ocr[0]) ^ s_r.op[0])))
        else $error("PWM channel 0 level wrong");

    AST_CAP_BLOCKED: assert property (
        (s_r.cf[0] & ~(rd & idx == pat_pkg::IDX_CAP1)) |=> $stable(s_r.icr[0]))
        else $error("Capture register changed while flag set");

    AST_CAP_LATCH: assert property (
        (cap_ev[0] & ~s_r.cf[0]) |=> (s_r.cf[0] && s_r.icr[0] == $past(s_r.cnt)))
        else $error("Capture did not latch counter");

    AST_OVF_READ_CLEAR: assert property (
        (rd & idx == pat_pkg::IDX_CSR & s_r.ovf_rd_ok & ~ovf_ev) |=> ~s_r.ovf)
        else $error("Overflow flag not cleared by read");

    AST_IRQ_OVF: assert property (
        (s_r.ovf & s_r.overflow_irq_enable) |-> irq_o)
        else $error("Enabled overflow without interrupt");

    AST_DIV128: assert property (
        (cnt_tick & s_r.cc == 3'h7) |-> (s_r.psc == 7'h7F))
        else $error("Divide by 128 tick at wrong prescaler count");

    AST_POL_IMMEDIATE: assert property (
        (wr & idx == pat_pkg::IDX_PWMCTL & ~cnt_tick & s_r.oe[0] & wdat[pat_pkg::PWM_OE_LSB]
            & (wdat[pat_pkg::PWM_OP_LSB] != s_r.op[0])) |=> $changed(pwm_output_pin_o[0]))
        else $error("Polarity change did not invert channel 0");

    AST_PWM_DISABLED_LOW: assert property (
        ~s_r.oe[1] |-> ~pwm_output_pin_o[1])
        else $error("Disabled channel 1 not low");

    AST_FORCE_RELOAD_LOAD: assert property (
        (wr & idx == pat_pkg::IDX_CSR & wdat[pat_pkg::CSR_FORCE_RELOAD]) |=>
            (s_r.cnt == $past(s_r.arr) && s_r.psc == 7'h00))
        else $error("Force reload did not load counter and clear prescaler");

    AST_CNT_WRITE: assert property (
        (wr & idx == pat_pkg::IDX_CNT) |=> (s_r.cnt == $past(wdat)))
        else $error("Counter write not taken");

    AST_RUN_STEP: assert property (
        (cnt_tick & ~ovf_ev & ~wr) |=> (s_r.cnt == $past(s_r.cnt) + 8'h01))
        else $error("Counter did not step on tick");

    AST_IRQ_CAP: assert property (
        (s_r.cf[1] & s_r.cie[1]) |-> irq_o)
        else $error("Enabled capture without interrupt");

    AST_IRQ_QUIET: assert property (
        ~((s_r.ovf & s_r.overflow_irq_enable) | (|(s_r.cf & s_r.cie))) |-> ~irq_o)
        else $error("Interrupt without enabled flag");

    COV_OVERFLOW: cover property (ovf_ev ##1 s_r.ovf);
    COV_CAPTURE: cover property (cap_ev[1] & ~s_r.cf[1]);
    COV_PWM_TOGGLE: cover property (pwm_output_pin_o[0] ##1 ~pwm_output_pin_o[0]);
    COV_FORCE_RELOAD: cover property (wr & idx == pat_pkg::IDX_CSR & wdat[pat_pkg::CSR_FORCE_RELOAD]);
    COV_CAP_BLOCKED: cover property (cap_ev[0] & s_r.cf[0]);

endmodule : pat_timer

//--- rtl/pat_pkg.sv
/*
 * Shared constants of the auto-reload PWM timer: register indexes, field
 * positions, reset value and bus widths.
 * Assumes a 32-bit APB register bus whose byte address is four times the index.
 */
package pat_pkg;

    // ----------------------------------------------------------------
    // Register indexes (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_DUTY3 = 6'h31;
    localparam logic [5:0] IDX_DUTY2 = 6'h32;
    localparam logic [5:0] IDX_DUTY1 = 6'h33;
    localparam logic [5:0] IDX_DUTY0 = 6'h34;
    localparam logic [5:0] IDX_PWMCTL = 6'h35;
    localparam logic [5:0] IDX_CSR = 6'h36;
    localparam logic [5:0] IDX_CNT = 6'h37;
    localparam logic [5:0] IDX_ARR = 6'h38;
    localparam logic [5:0] IDX_CAPCSR = 6'h39;
    localparam logic [5:0] IDX_CAP1 = 6'h3A;
    localparam logic [5:0] IDX_CAP2 = 6'h3B;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CSR_EXT_CLOCK_SELECT = 7;
    localparam int CSR_CC_LSB = 4;
    localparam int CSR_TCE = 3;
    localparam int CSR_FORCE_RELOAD = 2;
    localparam int CSR_OIE = 1;
    localparam int CSR_OVF = 0;
    localparam int PWM_OE_LSB = 4;
    localparam int PWM_OP_LSB = 0;
    localparam int CAP_CS_LSB = 4;
    localparam int CAP_CIE_LSB = 2;
    localparam int CAP_CF_LSB = 0;

    // ----------------------------------------------------------------
    // Reset value and counter limits
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hFF;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

endpackage : pat_pkg

//--- rtl/pat_cap_sync.sv
/*
 * Capture input synchroniser and edge detector for one capture channel.
 * Assumes the pin is asynchronous to clk_i; event_o is a one-cycle pulse.
 */
`timescale 1ns/10ps
module pat_cap_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic rising_sel_i,
    output logic event_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } pat_sync_st_t;

    pat_sync_st_t s_r;
    pat_sync_st_t s_nxt;

    // ----------------------------------------------------------------
    // Two-stage synchroniser plus history stage
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pin_i;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Edge select: 1 rising, 0 falling
    assign event_o = rising_sel_i ? (s_r.s2 & ~s_r.s3) : (~s_r.s2 & s_r.s3);

endmodule : pat_cap_sync

//--- bench/pat_far_pins.sv
/*
 * Far-side model: drives the external count clock and the capture pins.
 * Assumes the bench calls its tasks from one process, clocked by clk_i.
 */
`timescale 1ns/10ps
module pat_far_pins (
    input wire logic clk_i,
    output logic ext_clk_o,
    output logic [1:0] cap_o
);
    initial begin
        ext_clk_o = 1'b0;
        cap_o = 2'b10;
    end

    // One input tick is a low-high-low pulse of two cycles
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i) ext_clk_o <= 1'b1;
            @(posedge clk_i) ext_clk_o <= 1'b0;
        end
    endtask : tick

    // New pin levels, then time for two sync stages and the latch
    task automatic pins(input logic [1:0] v);
        @(posedge clk_i) cap_o <= v;
        repeat (5) @(posedge clk_i);
    endtask : pins
endmodule : pat_far_pins

//--- bench/testbench.sv
/*
 * Self-checking bench of the PWM timer: APB register tasks and sequences.
 * Assumes the zero-wait APB slave and the pin model pat_far_pins.
 */
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
    $display("BAD %0t got %h expected %h", $time, a, e); end end
module testbench;
    logic clk_i = 1'b0;
    logic rst_i;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic ext;
    logic [3:0] pwm;
    logic [3:0] oe;
    logic [1:0] cap;
    int errors = 0;
    int compares = 0;
    localparam logic [5:0] CSR = pat_pkg::IDX_CSR;
    localparam logic [5:0] CNT = pat_pkg::IDX_CNT;
    localparam logic [5:0] CAPCSR = pat_pkg::IDX_CAPCSR;

    always #20 clk_i = ~clk_i;

    pat_timer i_pat_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .ext_clk_i(ext),
        .capture_input_pin_i(cap),
        .pwm_output_pin_o(pwm),
        .pwm_output_pin_oe_o(oe),
        .irq_o(irq)
    );
    pat_far_pins i_pat_far_pins (
        .clk_i(clk_i),
        .ext_clk_o(ext),
        .cap_o(cap)
    );

    // ----------------------------------------------------------------
    // APB master
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rdc(input logic [5:0] idx, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        xfer(1'b0, idx, 8'h00, r, e);
        `CHK(r, {24'h0, x})
    endtask : rdc

    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic complete_run();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        rst_i <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 8'h31; i <= 8'h3B; i++) rdc(i[5:0], 8'h00);
        xfer(1'b0, 6'h00, 8'h00, r, e);
        `CHK(e, 1'b1)
        `CHK({pwm, oe, irq}, 9'h000)
        $display("reset test done");
        wr(CSR, 8'h76);
        rdc(CSR, 8'h72);
        wr(CNT, 8'h10);
        wr(CSR, 8'h08);
        wr(CSR, 8'h00);
        rdc(CNT, 8'h13);
        wr(pat_pkg::IDX_ARR, 8'hF0);
        wr(CNT, 8'h20);
        wr(CSR, 8'h80);
        i_pat_far_pins.tick(3);
        rdc(CNT, 8'h20);
        wr(CSR, 8'h88);
        i_pat_far_pins.tick(3);
        rdc(CNT, 8'h23);
        wr(CNT, 8'h30);
        wr(CSR, 8'h98);
        i_pat_far_pins.tick(4);
        rdc(CNT, 8'h32);
        wr(CNT, 8'h40);
        wr(CSR, 8'hF8);
        i_pat_far_pins.tick(128);
        rdc(CNT, 8'h41);
        wr(CSR, 8'hFC);
        wr(CSR, 8'h88);
        rdc(CNT, 8'hF0);
        wr(CNT, 8'hFF);
        i_pat_far_pins.tick(1);
        rdc(CNT, 8'hF0);
        rdc(CSR, 8'h89);
        rdc(CSR, 8'h88);
        wr(CSR, 8'h8A);
        wr(CNT, 8'hFF);
        i_pat_far_pins.tick(1);
        settle();
        `CHK(irq, 1'b1)
        rdc(CSR, 8'h8B);
        wr(CSR, 8'h88);
        wr(CNT, 8'hFF);
        i_pat_far_pins.tick(1);
        settle();
        `CHK(irq, 1'b0)
        $display("counter test done");
        wr(pat_pkg::IDX_ARR, 8'h00);
        wr(pat_pkg::IDX_DUTY0, 8'h80);
        wr(pat_pkg::IDX_PWMCTL, 8'h30);
        wr(CNT, 8'hFF);
        i_pat_far_pins.tick(1);
        settle();
        `CHK({oe, pwm}, 8'h33)
        i_pat_far_pins.tick(1);
        settle();
        `CHK(pwm, 4'h1)
        wr(pat_pkg::IDX_PWMCTL, 8'h31);
        #1;
        `CHK({oe, pwm}, 8'h30)
        wr(pat_pkg::IDX_DUTY1, 8'h05);
        settle();
        `CHK(pwm, 4'h0)
        wr(CNT, 8'hFF);
        i_pat_far_pins.tick(3);
        settle();
        `CHK(pwm, 4'h2)
        $display("pwm test done");
        wr(CSR, 8'h80);
        wr(CNT, 8'h55);
        wr(CAPCSR, 8'hFC);
        rdc(CAPCSR, 8'h3C);
        wr(CAPCSR, 8'h14);
        i_pat_far_pins.pins(2'b11);
        rdc(CAPCSR, 8'h15);
        settle();
        `CHK(irq, 1'b1)
        wr(CNT, 8'h66);
        i_pat_far_pins.pins(2'b10);
        i_pat_far_pins.pins(2'b11);
        rdc(pat_pkg::IDX_CAP1, 8'h55);
        rdc(CAPCSR, 8'h14);
        settle();
        `CHK(irq, 1'b0)
        i_pat_far_pins.pins(2'b01);
        rdc(CAPCSR, 8'h16);
        settle();
        `CHK(irq, 1'b0)
        rdc(pat_pkg::IDX_CAP2, 8'h66);
        i_pat_far_pins.pins(2'b00);
        rdc(CAPCSR, 8'h14);
        $display("capture test done");
        complete_run();
    end
endmodule : testbench
